// >>> inc/msrb_pkg.sv
// Constants and types of the monitor serial register bank.
// Assumes one 100 MHz clock; the serial pins are sampled by it.
package msrb_pkg;
  // Register pointer values
  localparam logic [7:0] ADDR_DAC  = 8'h19;
  localparam logic [7:0] ADDR_CFG  = 8'h40;
  localparam logic [7:0] ADDR_FLG1 = 8'h41;
  localparam logic [7:0] ADDR_FLG2 = 8'h42;
  localparam logic [7:0] ADDR_MSK1 = 8'h43;
  localparam logic [7:0] ADDR_MSK2 = 8'h44;
  localparam logic [7:0] ADDR_ICLR = 8'h46;
  localparam logic [7:0] ADDR_VIDF = 8'h47;
  localparam logic [7:0] ADDR_SADR = 8'h48;
  localparam logic [7:0] ADDR_VID5 = 8'h49;
  localparam logic [7:0] ADDR_TCFG = 8'h4B;
  localparam logic [7:0] ADDR_EXT1 = 8'h4C;
  localparam logic [7:0] ADDR_EXT2 = 8'h4D;
  // Value memory window 20h-3Fh
  localparam logic [2:0] MEM_PAGE  = 3'h1;
  // Values after reset
  localparam logic [7:0] RST_CFG   = 8'h08;
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic [3:0] RST_FDIV  = 4'h5;
  localparam logic [4:0] RST_SADR  = 5'h0B;
  localparam logic [6:0] VID5_HI   = 7'h40;
  localparam logic [7:0] RST_TCFG  = 8'h01;
  localparam logic [7:0] RST_EXT1  = 8'h44;
  localparam logic [7:0] RST_EXT2  = 8'h00;
  localparam logic [7:0] RST_DAC   = 8'hFF;
  // Field positions
  localparam int CFG_START = 0;
  localparam int CFG_INTEN = 1;
  localparam int CFG_ICLR  = 3;
  localparam int CFG_RSTO  = 4;
  localparam int CFG_INIT  = 7;
  localparam int ICLR_BIT  = 7;
  // Timing
  localparam int CLK_MHZ    = 100;
  localparam int PULSE_MS   = 20;
  localparam int TIMEOUT_MS = 35;
  localparam int PULSE_CYC  = PULSE_MS * 1000 * CLK_MHZ;
  localparam int TMO_CYC    = TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int CNT_W      = 22;

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_ACK, S_RX, S_TX, S_TXACK
  } msrb_bus_st_t;

  typedef struct packed {
    logic       run;
    logic [7:0] dac;
    logic [3:0] fan_div;
    logic [7:0] temp_cfg;
    logic [7:0] ext1;
    logic [7:0] ext2;
  } msrb_ctrl_t;

  typedef struct packed {
    logic       we;
    logic [4:0] addr;
    logic [7:0] data;
  } msrb_res_t;

  typedef struct packed {
    msrb_bus_st_t     st;
    logic [2:0]       bitcnt;
    logic [7:0]       sh;
    logic             rw;
    logic             first;
    logic             ack_on;
    logic             mack;
    logic             sda_oe;
    logic             int_oe;
    logic [7:0]       ptr;
    logic [CNT_W-1:0] tmo;
    logic [CNT_W-1:0] rpulse;
    logic [CNT_W-1:0] cpulse;
    logic             rguard;
    logic [7:0]       cfg;
    logic [7:0]       flg1;
    logic [7:0]       flg2;
    logic [7:0]       msk1;
    logic [7:0]       msk2;
    logic [7:0]       iclr;
    logic [3:0]       fdiv;
    logic [4:0]       sadr;
    logic [7:0]       tcfg;
    logic [7:0]       ext1;
    logic [7:0]       ext2;
    logic [7:0]       dac;
    logic             scl_m;
    logic             scl_s;
    logic             scl_p;
    logic             sda_m;
    logic             sda_s;
    logic             sda_p;
    logic             rpin_m;
    logic             rpin_s;
    logic [1:0]       a_m;
    logic [1:0]       a_s;
    logic [4:0]       vid_m;
    logic [4:0]       vid_s;
  } msrb_state_t;
endpackage : msrb_pkg

// >>> src/msrb_top.sv
// Serial slave front end and control register bank of a monitor.
// Assumes pins are asynchronous and an external engine supplies
// event pulses and conversion results on clk.
// Contract
// (RULE1) Write: address, pointer, then data byte
// (RULE2) Pointer-less read returns pointed register
// (RULE3) Pointer write, repeated start, then read
// (RULE4) Device acts only as slave
// (RULE5) Address defaults 01011 plus two pins
// (RULE6) Low address bits mirror select pins
// (RULE7) Long low line resets bus to idle
// (RULE8) Serial clock drives only bus interface
// (RULE9) Power-up loads control register defaults
// (RULE10) Value memory not initialised at power-up
// (RULE11) Reset pin low restores defaults
// (RULE12) Config bit 7 soft init, self clearing
// (RULE13) Soft init keeps slave address
// (RULE14) Soft init keeps value memory
// (RULE15) Power-up: engine stopped, interrupt cleared
// (RULE16) Config bit 0 starts/stops monitoring
// (RULE17) Registers accessible during shutdown
// (RULE18) Config bit 1 enables interrupt output
// (RULE19) Config bit 3 clears interrupt, pauses
// (RULE20) Config bit 4 gives reset pulse
// (RULE21) Intrusion clear gives intrusion pin pulse
// (RULE22) Fan divisors high, live VID low
// (RULE23) Fifth VID register bit 0 live
// (RULE24) Value memory window via pointer
// (RULE25) DAC setting survives soft init
// (RULE26) Host starts with clear low, start high
// (RULE27) Pointer kept between transactions
`timescale 1ns/10ps
module msrb_top
  import msrb_pkg::*;
#(
  parameter int PULSE_CYCLES   = msrb_pkg::PULSE_CYC,
  parameter int TIMEOUT_CYCLES = msrb_pkg::TMO_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe,
  input  wire logic                 addr_select_low,
  input  wire logic                 addr_select_high,
  input  wire logic [3:0]           voltage_id_inputs,
  input  wire logic                 voltage_id_fifth_input,
  input  wire logic                 reset_pin_n_i,
  output logic                      reset_pin_n_o,
  output logic                      reset_pin_n_oe,
  output logic                      chassis_intrusion_pin_n_o,
  output logic                      chassis_intrusion_pin_n_oe,
  output logic                      int_n_o,
  output logic                      int_n_oe,
  input  wire logic [7:0]           event_set_first,
  input  wire logic [7:0]           event_set_second,
  input  wire msrb_pkg::msrb_res_t  res,
  output msrb_pkg::msrb_ctrl_t      ctrl
);
  import msrb_pkg::*;

  if (PULSE_CYCLES < 8 || PULSE_CYCLES >= (1 << CNT_W)) begin : g_bad_p
    $error("PULSE_CYCLES out of range");
  end
  if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES >= (1 << CNT_W)) begin : g_bad_t
    $error("TIMEOUT_CYCLES out of range");
  end

  localparam logic [CNT_W-1:0] PULSE_LD = CNT_W'(PULSE_CYCLES);
  localparam logic [CNT_W-1:0] TMO_LAST = CNT_W'(TIMEOUT_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  localparam msrb_state_t ST_RST = '{
    st: S_IDLE, cfg: RST_CFG, fdiv: RST_FDIV, sadr: RST_SADR,
    tcfg: RST_TCFG, ext1: RST_EXT1, ext2: RST_EXT2, dac: RST_DAC,
    scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1, sda_m: 1'b1,
    sda_s: 1'b1, sda_p: 1'b1, rpin_m: 1'b1, rpin_s: 1'b1,
    default: '0
  };

  msrb_state_t q;
  msrb_state_t d;
  logic [7:0]  mem [32];
  logic        mem_we;
  logic [4:0]  mem_wa;
  logic [7:0]  mem_wd;
  logic        rise;
  logic        fall;
  logic        start;
  logic        stop;
  logic        wr_en;
  logic        rd_en;
  logic        load_tx;
  logic        ptr_load;
  logic        soft_init;
  logic        pin_rst;
  logic        tmo_hit;
  logic [7:0]  byte_in;
  logic [7:0]  rd_data;
  logic [6:0]  dev_addr;

  // Register read view
  function automatic logic [7:0] rd_reg(input logic [7:0] a);
    logic [7:0] r;
    r = RST_ZERO;
    case (a)
      ADDR_DAC:  r = q.dac;
      ADDR_CFG:  r = q.cfg;
      ADDR_FLG1: r = q.flg1;
      ADDR_FLG2: r = q.flg2;
      ADDR_MSK1: r = q.msk1;
      ADDR_MSK2: r = q.msk2;
      ADDR_ICLR: r = q.iclr;
      ADDR_VIDF: r = {q.fdiv, q.vid_s[3:0]};         // (RULE22)
      ADDR_SADR: r = {1'b0, q.sadr, q.a_s};          // (RULE6)
      ADDR_VID5: r = {VID5_HI, q.vid_s[4]};          // (RULE23)
      ADDR_TCFG: r = q.tcfg;
      ADDR_EXT1: r = q.ext1;
      ADDR_EXT2: r = q.ext2;
      default: begin
        if (a[7:5] == MEM_PAGE) begin
          r = mem[a[4:0]];                           // (RULE24)
        end
      end
    endcase
    return r;
  endfunction : rd_reg

  assign rd_data  = rd_reg(q.ptr);
  assign dev_addr = {q.sadr, q.a_s};                 // (RULE5) (RULE6)
  assign byte_in  = {q.sh[6:0], q.sda_s};
  assign rise     = q.scl_s & ~q.scl_p;
  assign fall     = ~q.scl_s & q.scl_p;
  assign start    = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
  assign stop     = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
  assign tmo_hit  = (~q.scl_s | ~q.sda_s) && (q.tmo >= TMO_LAST);
  assign pin_rst  = ~q.rpin_s & ~q.rguard;           // (RULE11)

  always_comb begin
    d         = q;
    mem_we    = 1'b0;
    mem_wa    = res.addr;
    mem_wd    = res.data;
    wr_en     = 1'b0;
    rd_en     = 1'b0;
    load_tx   = 1'b0;
    ptr_load  = 1'b0;
    soft_init = 1'b0;

    // Two-flop synchronisers, plus a history flop for edges
    d.scl_m  = scl_i;
    d.scl_s  = q.scl_m;
    d.scl_p  = q.scl_s;
    d.sda_m  = sda_i;
    d.sda_s  = q.sda_m;
    d.sda_p  = q.sda_s;
    d.rpin_m = reset_pin_n_i;
    d.rpin_s = q.rpin_m;
    d.a_m    = {addr_select_high, addr_select_low};
    d.a_s    = q.a_m;
    d.vid_m  = {voltage_id_fifth_input, voltage_id_inputs};
    d.vid_s  = q.vid_m;

    // Bus engine; scl edges only step this part (RULE8)
    if (start) begin
      d.st     = S_ADDR;
      d.bitcnt = 3'd0;
      d.first  = 1'b1;
      d.ack_on = 1'b0;
      d.sda_oe = 1'b0;
    end else if (stop) begin
      d.st     = S_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        S_IDLE: begin
        end
        S_ADDR, S_RX: begin
          if (rise) begin
            d.sh     = byte_in;
            d.bitcnt = q.bitcnt + 3'd1;
            if (q.bitcnt == 3'd7) begin
              if (q.st == S_ADDR) begin
                if (byte_in[7:1] == dev_addr) begin
                  d.rw = byte_in[0];
                  d.st = S_ACK;
                end else begin
                  d.st = S_IDLE;
                end
              end else begin
                d.st    = S_ACK;
                d.first = 1'b0;
                if (q.first) begin
                  d.ptr    = byte_in;                // (RULE1) (RULE3)
                  ptr_load = 1'b1;
                end else begin
                  wr_en = 1'b1;                      // (RULE1)
                end
              end
            end
          end
        end
        S_ACK: begin
          if (fall) begin
            if (!q.ack_on) begin
              d.ack_on = 1'b1;
              d.sda_oe = 1'b1;
            end else begin
              d.ack_on = 1'b0;
              d.sda_oe = 1'b0;
              d.bitcnt = 3'd0;
              if (q.rw) begin
                load_tx = 1'b1;                      // (RULE2)
              end else begin
                d.st = S_RX;
              end
            end
          end
        end
        S_TX: begin
          if (fall) begin
            if (q.bitcnt == 3'd7) begin
              d.sda_oe = 1'b0;
              d.st     = S_TXACK;
            end else begin
              d.sh     = {q.sh[6:0], 1'b0};
              d.sda_oe = ~q.sh[6];
              d.bitcnt = q.bitcnt + 3'd1;
            end
          end
        end
        S_TXACK: begin
          if (rise) begin
            d.mack = ~q.sda_s;
          end
          if (fall) begin
            if (q.mack) begin
              load_tx = 1'b1;
            end else begin
              d.st = S_IDLE;
            end
          end
        end
      endcase
    end

    // Data byte out; a following byte rereads the same pointer
    if (load_tx) begin
      rd_en    = 1'b1;
      d.sh     = rd_data;
      d.sda_oe = ~rd_data[7];
      d.bitcnt = 3'd0;
      d.st     = S_TX;
    end

    // Stuck-low watchdog (RULE7)
    if (q.scl_s & q.sda_s) begin
      d.tmo = '0;
    end else if (!tmo_hit) begin
      d.tmo = q.tmo + CNT_ONE;
    end
    if (tmo_hit) begin
      d.st     = S_IDLE;
      d.sda_oe = 1'b0;
      d.ack_on = 1'b0;
    end

    // Pulse timers
    if (q.rpulse != '0) begin
      d.rpulse = q.rpulse - CNT_ONE;
      if (q.rpulse == CNT_ONE) begin
        d.cfg[CFG_RSTO] = 1'b0;
      end
    end else if (q.rpin_s) begin
      d.rguard = 1'b0;
    end
    if (q.cpulse != '0) begin
      d.cpulse = q.cpulse - CNT_ONE;
      if (q.cpulse == CNT_ONE) begin
        d.iclr[ICLR_BIT] = 1'b0;
      end
    end

    // Register writes, open in any run state (RULE17)
    if (wr_en) begin
      case (q.ptr)
        ADDR_DAC:  d.dac  = byte_in;
        ADDR_CFG: begin
          d.cfg = byte_in;                           // (RULE16) (RULE19)
          soft_init = byte_in[CFG_INIT];             // (RULE12)
          if (byte_in[CFG_RSTO] && q.rpulse == '0) begin
            d.rpulse = PULSE_LD;                     // (RULE20)
            d.rguard = 1'b1;
          end
        end
        ADDR_MSK1: d.msk1 = byte_in;
        ADDR_MSK2: d.msk2 = byte_in;
        ADDR_ICLR: begin
          d.iclr = byte_in;
          if (byte_in[ICLR_BIT] && q.cpulse == '0) begin
            d.cpulse = PULSE_LD;                     // (RULE21)
          end
        end
        ADDR_VIDF: d.fdiv = byte_in[7:4];            // (RULE22)
        ADDR_SADR: d.sadr = byte_in[6:2];            // (RULE5)
        ADDR_TCFG: d.tcfg = byte_in;
        ADDR_EXT1: d.ext1 = byte_in;
        ADDR_EXT2: d.ext2 = byte_in;
        default: begin
          if (q.ptr[7:5] == MEM_PAGE) begin
            mem_we = 1'b1;                           // (RULE24)
            mem_wa = q.ptr[4:0];
            mem_wd = byte_in;
          end
        end
      endcase
    end else if (res.we) begin
      mem_we = 1'b1;
    end

    // Defaults; address and memory untouched (RULE13) (RULE14)
    if (soft_init || pin_rst) begin
      d.cfg    = RST_CFG;                            // (RULE12) (RULE15)
      d.flg1   = RST_ZERO;
      d.flg2   = RST_ZERO;
      d.msk1   = RST_ZERO;
      d.msk2   = RST_ZERO;
      d.iclr   = RST_ZERO;
      d.fdiv   = RST_FDIV;
      d.tcfg   = RST_TCFG;
      d.ext1   = RST_EXT1;
      d.ext2   = RST_EXT2;
      d.rpulse = '0;
      d.cpulse = '0;
      if (pin_rst) begin
        d.dac = RST_DAC;                             // (RULE11) (RULE25)
      end
    end

    // Flags clear on read; a new event in that cycle still sets
    if (rd_en && q.ptr == ADDR_FLG1) begin
      d.flg1 = RST_ZERO;
    end
    if (rd_en && q.ptr == ADDR_FLG2) begin
      d.flg2 = RST_ZERO;
    end
    d.flg1 = d.flg1 | event_set_first;
    d.flg2 = d.flg2 | event_set_second;

    // Interrupt: mask bit low passes a flag (RULE18) (RULE19)
    d.int_oe = q.cfg[CFG_INTEN] & ~q.cfg[CFG_ICLR]
             & (|((q.flg1 & ~q.msk1) | (q.flg2 & ~q.msk2)));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= ST_RST;                                   // (RULE9) (RULE15)
    end else begin
      q <= d;
    end
  end

  // No reset on the memory: contents start unknown (RULE10)
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Open-drain pins: drive low only (RULE4)
  assign sda_o                      = 1'b0;
  assign sda_oe                     = q.sda_oe;
  assign reset_pin_n_o              = 1'b0;
  assign reset_pin_n_oe             = (q.rpulse != '0);
  assign chassis_intrusion_pin_n_o  = 1'b0;
  assign chassis_intrusion_pin_n_oe = (q.cpulse != '0);
  assign int_n_o                    = 1'b0;
  assign int_n_oe                   = q.int_oe;
  assign ctrl = '{
    run:      q.cfg[CFG_START] & ~q.cfg[CFG_ICLR],   // (RULE16) (RULE19)
    dac:      q.dac,
    fan_div:  q.fdiv,
    temp_cfg: q.tcfg,
    ext1:     q.ext1,
    ext2:     q.ext2
  };

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_addr_hit;
    q.st == S_ADDR && rise && !start && !stop && !tmo_hit
      && q.bitcnt == 3'd7 && byte_in[7:1] == dev_addr;
  endsequence
  sequence s_ack_low;
    ##[1:400] q.sda_oe;
  endsequence

  a_addr_ack_drive: assert property (             // (RULE5)
    s_addr_hit |-> s_ack_low)
    else $error("matched address not acknowledged");
  a_slave_only: assert property (                 // (RULE4)
    q.sda_oe |-> (q.st == S_ACK || q.st == S_TX))
    else $error("data line driven outside ack or read");
  a_timeout_idle: assert property (               // (RULE7)
    tmo_hit |=> (q.st == S_IDLE && !q.sda_oe))
    else $error("bus not idle after timeout");
  a_soft_init_dflt: assert property (             // (RULE12)
    soft_init && !res.we |=> (q.cfg == RST_CFG && q.msk1 == RST_ZERO))
    else $error("soft init did not restore defaults");
  a_sadr_dac_kept: assert property (              // (RULE13)
    soft_init && !pin_rst |=> $stable(q.sadr) && $stable(q.dac))
    else $error("soft init altered address or dac");
  a_int_gate: assert property (                   // (RULE18)
    int_n_oe |-> $past(q.cfg[CFG_INTEN] && !q.cfg[CFG_ICLR]))
    else $error("interrupt driven while disabled or cleared");
  a_rstout_pulse: assert property (               // (RULE20)
    $rose(reset_pin_n_oe) |-> reset_pin_n_oe [*8])
    else $error("reset output pulse too short");
  a_ci_pulse: assert property (                   // (RULE21)
    $rose(chassis_intrusion_pin_n_oe) |-> chassis_intrusion_pin_n_oe [*8])
    else $error("intrusion pulse too short");
  a_ptr_kept: assert property (                   // (RULE27)
    $changed(q.ptr) |-> $past(ptr_load))
    else $error("pointer changed without pointer byte");
endmodule : msrb_top

// >>> testbench/msrb_host.sv
// Serial bus host model: drives the bus clock, pulls data low.
// Assumes a pulled-up data wire fed back on sda and a 100 MHz clk.
`timescale 1ns/10ps
module msrb_host (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe
);
  initial begin
    scl    = 1'b1;
    sda_oe = 1'b0;
  end

  // Quarter of a 160 ns bus period
  task automatic q(input int n);
    repeat (n * 4) @(negedge clk);
  endtask : q

  // Start or repeated start; clock stands high between frames
  task automatic start;
    sda_oe = 1'b0;
    q(1);
    scl = 1'b1;
    q(1);
    sda_oe = 1'b1;
    q(1);
    scl = 1'b0;
    q(1);
  endtask : start

  task automatic stop;
    sda_oe = 1'b1;
    q(1);
    scl = 1'b1;
    q(1);
    sda_oe = 1'b0;
    q(2);
  endtask : stop

  // Data set in the low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    sda_oe = ~b;
    q(1);
    scl = 1'b1;
    q(1);
    r = sda;
    q(1);
    scl = 1'b0;
    q(1);
  endtask : bit_io

  // Byte out MSB first; ok when the ninth bit was pulled low
  task automatic tx(input logic [7:0] b, output logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ok = ~r;
  endtask : tx

  // Byte in, then a no-acknowledge to end the read
  task automatic rx(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
  endtask : rx

  task automatic wr(input logic [6:0] a, input logic [7:0] p, d,
                    output logic ok);
    logic k1, k2, k3;
    start;
    tx({a, 1'b0}, k1);
    tx(p, k2);
    tx(d, k3);
    stop;
    ok = k1 & k2 & k3;
  endtask : wr

  // With use_p the pointer is loaded first, then a repeated start
  task automatic rd(input logic [6:0] a, input logic [7:0] p,
                    input logic use_p, output logic [7:0] d,
                    output logic ok);
    logic k1, k2, k3;
    k1 = 1'b1;
    k2 = 1'b1;
    if (use_p) begin
      start;
      tx({a, 1'b0}, k1);
      tx(p, k2);
    end
    start;
    tx({a, 1'b1}, k3);
    rx(d);
    stop;
    ok = k1 & k2 & k3;
  endtask : rd
endmodule : msrb_host

// >>> testbench/tb.sv
// Self-checking bench of the monitor serial register bank.
// Assumes the msrb_host model and shortened pulse/timeout counts.
`timescale 1ns/10ps
`define CHK(a, e) begin \
  n_tests++; \
  if ((a) !== (e)) begin \
    num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); \
  end \
end
module tb;
  import msrb_pkg::*;
  localparam int PC = 50;
  // Longest run with no high-high moment is about 15 bit periods
  localparam int TC = 400;
  typedef struct packed {
    logic [7:0] p;
    logic       w;
    logic [7:0] d;
    logic [7:0] e;
  } msrb_row_t;
  logic       clk, rst, scl, h_oe, sda, sda_o, sda_oe, ok;
  logic       a_lo, a_hi, vid5, rpin_drv, rpin, rpo, rpoe;
  logic       ci_o, ci_oe, int_o, int_oe;
  logic [3:0] vid;
  logic [7:0] ev1, ev2, rd_d;
  logic [6:0] adr;
  msrb_res_t  res;
  msrb_ctrl_t ctrl;
  int         num_errors, n_tests, rcnt, ccnt;
  msrb_row_t  rows [23] = '{
    '{8'h40, 1'b0, 8'h00, 8'h08}, '{8'h41, 1'b0, 8'h00, 8'h00},
    '{8'h42, 1'b0, 8'h00, 8'h00}, '{8'h43, 1'b0, 8'h00, 8'h00},
    '{8'h44, 1'b0, 8'h00, 8'h00}, '{8'h46, 1'b0, 8'h00, 8'h00},
    '{8'h4B, 1'b0, 8'h00, 8'h01}, '{8'h4C, 1'b0, 8'h00, 8'h44},
    '{8'h4D, 1'b0, 8'h00, 8'h00}, '{8'h19, 1'b0, 8'h00, 8'hFF},
    '{8'h47, 1'b0, 8'h00, 8'h59}, '{8'h48, 1'b0, 8'h00, 8'h2E},
    '{8'h49, 1'b0, 8'h00, 8'h81}, '{8'h43, 1'b1, 8'hA5, 8'hA5},
    '{8'h44, 1'b1, 8'h5A, 8'h5A}, '{8'h4C, 1'b1, 8'h11, 8'h11},
    '{8'h4D, 1'b1, 8'h3C, 8'h3C}, '{8'h19, 1'b1, 8'h12, 8'h12},
    '{8'h25, 1'b1, 8'h77, 8'h77}, '{8'h41, 1'b1, 8'hFF, 8'h00},
    '{8'h49, 1'b1, 8'h00, 8'h81}, '{8'h47, 1'b1, 8'hF0, 8'hF9},
    '{8'h50, 1'b1, 8'hAA, 8'h00}};

  assign sda  = ~(h_oe | (sda_oe & ~sda_o));
  assign rpin = rpin_drv & ~(rpoe & ~rpo);

  initial clk = 1'b0;
  always #5 clk = ~clk;

  always @(posedge clk) begin
    if (rpoe === 1'b1) begin
      rcnt++;
    end
    if (ci_oe === 1'b1) begin
      ccnt++;
    end
  end

  msrb_host u_host (.clk(clk), .sda(sda), .scl(scl), .sda_oe(h_oe));

  msrb_top #(.PULSE_CYCLES(PC), .TIMEOUT_CYCLES(TC)) u_dut (
    .clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .addr_select_low(a_lo), .addr_select_high(a_hi),
    .voltage_id_inputs(vid), .voltage_id_fifth_input(vid5),
    .reset_pin_n_i(rpin), .reset_pin_n_o(rpo), .reset_pin_n_oe(rpoe),
    .chassis_intrusion_pin_n_o(ci_o), .chassis_intrusion_pin_n_oe(ci_oe),
    .int_n_o(int_o), .int_n_oe(int_oe), .event_set_first(ev1),
    .event_set_second(ev2), .res(res), .ctrl(ctrl));

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic rdchk(input logic [7:0] p, e);
    u_host.rd(adr, p, 1'b1, rd_d, ok);
    `CHK({ok, rd_d}, {1'b1, e})
  endtask : rdchk

  task automatic wrchk(input logic [7:0] p, d);
    u_host.wr(adr, p, d, ok);
    `CHK(ok, 1'b1)
  endtask : wrchk

  task automatic end_of_test;
    $display("comparisons=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    end_of_test;
  end

  initial begin
    rst = 1'b1;
    a_lo = 1'b0;
    a_hi = 1'b1;
    vid = 4'h9;
    vid5 = 1'b1;
    rpin_drv = 1'b1;
    ev1 = 8'h00;
    ev2 = 8'h00;
    res = '0;
    adr = 7'h2E;
    cyc(8);
    rst = 1'b0;
    cyc(5);
    `CHK({int_oe, ctrl.run, rpoe, ci_oe, ctrl.dac}, 12'h0FF)
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wrchk(rows[i].p, rows[i].d);
      end
      rdchk(rows[i].p, rows[i].e);
    end
    vid = 4'h6;
    vid5 = 1'b0;
    cyc(5);
    rdchk(ADDR_VIDF, 8'hF6);
    rdchk(ADDR_VID5, 8'h80);
    `CHK({ctrl.fan_div, ctrl.dac}, 12'hF12)
    u_host.rd(adr, 8'h00, 1'b0, rd_d, ok);
    `CHK({ok, rd_d}, 9'h180)
    // Events while the clear bit is still set from reset
    ev1 = 8'h02;
    ev2 = 8'h04;
    cyc(1);
    ev1 = 8'h00;
    ev2 = 8'h00;
    cyc(3);
    `CHK(int_oe, 1'b0)
    wrchk(ADDR_CFG, 8'h01);
    `CHK({int_oe, ctrl.run}, 2'b01)
    wrchk(ADDR_CFG, 8'h03);
    `CHK({int_oe, ctrl.run}, 2'b11)
    wrchk(ADDR_CFG, 8'h0B);
    `CHK({int_oe, ctrl.run}, 2'b00)
    rdchk(ADDR_FLG1, 8'h02);
    rdchk(ADDR_FLG2, 8'h04);
    rcnt = 0;
    ccnt = 0;
    wrchk(ADDR_CFG, 8'h10);
    cyc(PC + 20);
    `CHK(rcnt, PC)
    rdchk(ADDR_CFG, 8'h00);
    wrchk(ADDR_ICLR, 8'h80);
    cyc(PC + 20);
    `CHK(ccnt, PC)
    wrchk(ADDR_SADR, 8'h54);
    adr = 7'h56;
    rdchk(ADDR_SADR, 8'h56);
    u_host.wr(7'h2E, ADDR_MSK1, 8'h00, ok);
    `CHK(ok, 1'b0)
    a_lo = 1'b1;
    adr = 7'h57;
    cyc(5);
    rdchk(ADDR_SADR, 8'h57);
    res = '{we: 1'b1, addr: 5'h06, data: 8'h9C};
    cyc(1);
    res = '0;
    rdchk(8'h26, 8'h9C);
    wrchk(ADDR_CFG, 8'h80);
    rdchk(ADDR_CFG, RST_CFG);
    rdchk(ADDR_MSK1, 8'h00);
    rdchk(ADDR_VIDF, 8'h56);
    rdchk(ADDR_DAC, 8'h12);
    rdchk(8'h25, 8'h77);
    rdchk(8'h26, 8'h9C);
    rdchk(ADDR_SADR, 8'h57);
    wrchk(ADDR_MSK1, 8'hAA);
    rpin_drv = 1'b0;
    cyc(6);
    rpin_drv = 1'b1;
    cyc(5);
    rdchk(ADDR_DAC, RST_DAC);
    rdchk(ADDR_MSK1, 8'h00);
    // Hang a read while the device drives a low data bit
    u_host.start;
    u_host.tx({adr, 1'b1}, ok);
    cyc(TC + 100);
    `CHK(sda_oe, 1'b0)
    u_host.stop;
    u_host.rd(adr, 8'h00, 1'b0, rd_d, ok);
    `CHK({ok, rd_d}, 9'h100)
    end_of_test;
  end
endmodule : tb
